// ==== core/wct_pkg.sv ====
package wct_pkg;

	// ==========================================================
	// timing
	localparam int CLK_HZ         = 25_000_000;
	localparam int XTAL_HZ        = 32_768;
	localparam int DEBOUNCE_US    = 1000;
	localparam int DEBOUNCE_CYC   = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int PRE_W          = 15;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(XTAL_HZ - 1);

	// ==========================================================
	// counter and compare
	localparam int CNT_W                 = 24;
	localparam logic [CNT_W-1:0] CNT_RST  = 24'h000000;
	localparam logic [CNT_W-1:0] WAKE_RST = 24'h000000;

	// ==========================================================
	// serial slave
	// value is arbitrary
	localparam logic [6:0] DEV_ADDR      = 7'h32;
	localparam logic [3:0] BIT_ACK       = 4'h8;
	localparam logic [3:0] BIT_LAST      = 4'h7;

	typedef enum logic [2:0] {
		WCT_PH_ADDR      = 3'b000,
		WCT_PH_DATA_HI   = 3'b001,
		WCT_PH_DATA_MID  = 3'b010,
		WCT_PH_DATA_LO   = 3'b011,
		WCT_PH_WAIT_STOP = 3'b100,
		WCT_PH_IGNORE    = 3'b101
	} wct_phase_t;

	typedef struct packed {
		logic             last_sda;
		logic [3:0]       bitcnt;
		logic [7:0]       shreg;
		wct_phase_t       ph;
		logic [15:0]      stage;
		logic [CNT_W-1:0] wake_buf;
		logic             ack;
		logic             tgl;
	} wct_rise_t;

	typedef struct packed {
		logic fall_sda;
		logic sda_oe;
		logic sda_o;
	} wct_fall_t;

	typedef struct packed {
		logic [2:0]       xs;
		logic [1:0]       rs;
		logic [PRE_W-1:0] deb;
		logic             run;
		logic [PRE_W-1:0] pre;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] wake;
		logic [2:0]       ts;
		logic             irq;
	} wct_core_t;

endpackage

// ==== core/wct_timer.sv ====
// ==========================================================
// falling-edge half of the serial slave: samples data at the
// falling clock edge and drives the acknowledge low
module wct_fall_stage
	import wct_pkg::*;
(
	input  wire logic scl,
	input  wire logic rst_b,
	input  wire logic sda_i,
	input  wire logic ack,
	output wct_fall_t st
);
	wct_fall_t next_st;

	always_comb begin
		next_st          = st;
		next_st.fall_sda = sda_i;
		next_st.sda_oe   = ack;
		next_st.sda_o    = 1'b0;
	end

	always_ff @(negedge scl or negedge rst_b) begin
		if (!rst_b) begin
			st <= '{fall_sda: 1'b1, sda_oe: 1'b0, sda_o: 1'b0};
		end else begin
			st <= next_st;
		end
	end
endmodule

// Behaviour
// - The timer is a 24-bit binary counter that only counts up.
// - The running count is compared with the stored wake-up time and the interrupt is raised when they match.
// - While the debounced timer reset input is low the counter is held at zero.
// - When the debounced timer reset input goes high the counter starts counting.
// - The timer reset input passes a debounce filter so short glitches neither reset nor restart the counter.
// - The host writes the wake-up time over the two-wire bus and the device takes it as the new compare target.
// - The time base comes from the 32.768 kHz crystal clock.
// - The wake-up time is set in whole seconds from one second up to about 194 days.
// - The host supplies the serial clock and the device samples and drives data in step with it.
// - The device only pulls the data line low as an open drain and otherwise releases it.
module wct_timer
	import wct_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic clk_en,
	input  wire logic xtal_clk,
	input  wire logic tmr_rst_b,
	input  wire logic scl,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	output logic      irq
);
	localparam logic [PRE_W-1:0] DEB_LAST = PRE_W'(DEBOUNCE_CYCLES - 1);

	wct_rise_t rs;
	wct_rise_t next_rs;
	wct_fall_t fs;
	wct_core_t cs;
	wct_core_t next_cs;

	// ==========================================================
	// serial slave, link clock domain
	// the bus has no free-running clock here, so start is seen as
	// data high at a rising edge and low at the following falling
	// edge; a stop followed by start is only tracked after our own
	// completed write
	wct_fall_stage u_fall (
		.scl   (scl),
		.rst_b (rst_b),
		.sda_i (sda_i),
		.ack   (rs.ack),
		.st    (fs)
	);

	always_comb begin
		logic       start;
		logic [7:0] full;
		start            = rs.last_sda & ~fs.fall_sda;
		full             = {rs.shreg[6:0], sda_i};
		next_rs          = rs;
		next_rs.last_sda = sda_i;
		if (start) begin
			next_rs.ph     = WCT_PH_ADDR;
			next_rs.shreg  = {7'h00, sda_i};
			next_rs.bitcnt = 4'h1;
			next_rs.ack    = 1'b0;
		end else if (rs.ph == WCT_PH_WAIT_STOP) begin
			// this rising edge belongs to the stop condition
			next_rs.ph     = WCT_PH_ADDR;
			next_rs.bitcnt = 4'h0;
		end else if (rs.bitcnt == BIT_ACK) begin
			next_rs.bitcnt = 4'h0;
			next_rs.ack    = 1'b0;
			if (!rs.ack) begin
				next_rs.ph = WCT_PH_IGNORE;
			end else begin
				unique case (rs.ph)
					WCT_PH_ADDR: begin
						next_rs.ph = WCT_PH_DATA_HI;
					end
					WCT_PH_DATA_HI: begin
						next_rs.stage[15:8] = rs.shreg;
						next_rs.ph          = WCT_PH_DATA_MID;
					end
					WCT_PH_DATA_MID: begin
						next_rs.stage[7:0] = rs.shreg;
						next_rs.ph         = WCT_PH_DATA_LO;
					end
					WCT_PH_DATA_LO: begin
						next_rs.wake_buf = {rs.stage, rs.shreg};
						next_rs.tgl      = ~rs.tgl;
						next_rs.ph       = WCT_PH_WAIT_STOP;
					end
					default: begin
						next_rs.ph = WCT_PH_IGNORE;
					end
				endcase
			end
		end else begin
			next_rs.shreg  = full;
			next_rs.bitcnt = rs.bitcnt + 4'h1;
			if (rs.bitcnt == BIT_LAST) begin
				if (rs.ph == WCT_PH_ADDR) begin
					// only a write to our address is answered
					next_rs.ack = (full[7:1] == DEV_ADDR) && !full[0];
				end else begin
					next_rs.ack = (rs.ph != WCT_PH_IGNORE);
				end
			end
		end
	end

	always_ff @(posedge scl or negedge rst_b) begin
		if (!rst_b) begin
			rs <= '{last_sda: 1'b1, bitcnt: 4'h0, shreg: 8'h00, ph: WCT_PH_ADDR,
				stage: 16'h0000, wake_buf: WAKE_RST, ack: 1'b0, tgl: 1'b0};
		end else begin
			rs <= next_rs;
		end
	end

	// ==========================================================
	// timer core, system clock domain
	always_comb begin
		logic             xtal_rise;
		logic [CNT_W-1:0] cnt_inc;
		xtal_rise  = cs.xs[1] & ~cs.xs[2];
		cnt_inc    = cs.count + 24'h000001;
		next_cs    = cs;
		next_cs.xs = {cs.xs[1:0], xtal_clk};
		next_cs.rs = {cs.rs[0], tmr_rst_b};
		next_cs.ts = {cs.ts[1:0], rs.tgl};

		// level must hold for the whole window before it is taken
		if (cs.rs[1] == cs.run) begin
			next_cs.deb = '0;
		end else if (cs.deb == DEB_LAST) begin
			next_cs.deb = '0;
			next_cs.run = cs.rs[1];
		end else begin
			next_cs.deb = cs.deb + 15'h0001;
		end

		// wake buffer is stable for a whole byte time after the toggle
		if (cs.ts[1] ^ cs.ts[2]) begin
			next_cs.wake = rs.wake_buf;
			next_cs.irq  = 1'b0;
		end

		if (!cs.run) begin
			next_cs.pre   = '0;
			next_cs.count = CNT_RST;
			next_cs.irq   = 1'b0;
		end else if (xtal_rise) begin
			if (cs.pre == PRE_LAST) begin
				next_cs.pre   = '0;
				next_cs.count = cnt_inc;
				if (cnt_inc == next_cs.wake) begin
					next_cs.irq = 1'b1;
				end
			end else begin
				next_cs.pre = cs.pre + 15'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs <= '{xs: 3'h0, rs: 2'h0, deb: 15'h0000, run: 1'b0, pre: 15'h0000,
				count: CNT_RST, wake: WAKE_RST, ts: 3'h0, irq: 1'b0};
		end else if (clk_en) begin
			cs <= next_cs;
		end
	end

	// ==========================================================
	// outputs, each straight from a flip-flop
	assign irq    = cs.irq;
	assign sda_oe = fs.sda_oe;
	assign sda_o  = fs.sda_o;
endmodule

// ==== tb/tb_wct_timer.sv ====
module tb_wct_timer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEB = 8;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        xtal_clk = 1'b0;
	logic        tmr_rst_b = 1'b0;
	logic        run = 1'b0;
	logic        scl;
	logic        sda_h;
	logic        sda_o;
	logic        sda_oe;
	logic        irq;
	logic [6:0]  a;
	logic [23:0] wake = 24'h000001;
	wire         sda = sda_h & !sda_oe;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          edges = 0;
	int          cyc = 0;
	int          acks;
	always #20 clk = ~clk;
	// crystal sped up so one second of counting fits the cycle budget; each level still spans a clk edge
	always #50 xtal_clk = ~xtal_clk;
	// model: crystal edges counted while the timer runs
	always @(posedge xtal_clk) if (run) edges++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			miscompares++;
			give_verdict();
		end
	end
	wct_timer #(.DEBOUNCE_CYCLES(DEB)) u_wct_timer (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .xtal_clk(xtal_clk),
		.tmr_rst_b(tmr_rst_b), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	wct_host_model u_wct_host_model (.scl(scl), .sda_h(sda_h), .sda(sda));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h9103488F));
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		chk(irq, 0);
		chk(sda_oe, 0);
		$display("test done: reset");
		u_wct_host_model.frame({wct_pkg::DEV_ADDR, 1'b0, wake}, acks);
		chk(acks, 4);
		chk(sda_o, 0);
		a = 7'($urandom);
		if (a == wct_pkg::DEV_ADDR) a = ~a;
		u_wct_host_model.frame({a, 1'b0, 24'($urandom)}, acks);
		chk(acks, 0);
		$display("test done: serial");
		@(negedge clk) tmr_rst_b = 1'b1;
		repeat (DEB + 2) @(negedge clk);
		run = 1'b1;
		repeat (500) @(negedge clk);
		// glitch shorter than the debounce time
		tmr_rst_b = 1'b0;
		repeat (1 + $urandom % 4) @(negedge clk);
		tmr_rst_b = 1'b1;
		wait (edges >= 32760);
		@(negedge clk) chk(irq, 32'(edges / 32768 == wake));
		wait (edges >= 32776);
		@(negedge clk) chk(irq, 32'(edges / 32768 == wake));
		tmr_rst_b = 1'b0;
		run = 1'b0;
		repeat (DEB + 8) @(negedge clk);
		chk(irq, 0);
		$display("test done: timer");
		give_verdict();
	end
endmodule

// ==== tb/wct_host_model.sv ====
module wct_host_model (
	output logic     scl,
	output logic     sda_h,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic s;
	// scl stands high between frames
	initial scl = 1'b1;
	initial sda_h = 1'b1;
	task automatic put(input logic b);
		scl = 1'b0;
		#6 sda_h = b;
		#18 scl = 1'b1;
		#12 s = sda;
		#12;
	endtask
	// start, address byte, three wake bytes msb first, stop
	task automatic frame(input logic [31:0] w, output int acks);
		acks = 0;
		scl = 1'b0;
		#24 scl = 1'b1;
		#12 sda_h = 1'b0;
		#12;
		for (int i = 31; i >= 0; i--) begin
			put(w[i]);
			if (i % 8 == 0) begin
				put(1'b1);
				acks += int'(!s);
			end
		end
		scl = 1'b0;
		#6 sda_h = 1'b0;
		#18 scl = 1'b1;
		#12 sda_h = 1'b1;
	endtask
endmodule

// ==== tb/wct_timer_checker.sv ====
module wct_timer_checker #(
	parameter int DEBOUNCE_CYCLES = 8
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic xtal_clk,
	input wire logic tmr_rst_b,
	input wire logic scl,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic irq
);
	// ==========================================================
	// helper: pin low time, scl quiet time, crystal edges since release
	int lo;
	int qt;
	int xr;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lo <= 0;
			qt <= 0;
			xr <= 0;
		end else begin
			lo <= tmr_rst_b ? 0 : lo + 1;
			qt <= (scl != $past(scl)) ? 0 : qt + 1;
			// over-counts edges, so the bound below stays a safe lower bound
			xr <= (lo >= DEBOUNCE_CYCLES) ? 0 : xr + int'(xtal_clk && !$past(xtal_clk));
		end
	end
	// ==========================================================
	// assertions
	a_sda_low_only: assert property (sda_oe |-> !sda_o) else $error("sda high");
	a_ack_short: assert property (sda_oe ##1 sda_oe |=> !sda_oe) else $error("ack long");
	a_ack_in_frame: assert property (sda_oe |-> qt < 4) else $error("ack idle");
	a_tmr_clears: assert property (lo > DEBOUNCE_CYCLES + 4 |-> !irq) else $error("irq kept");
	a_irq_not_held: assert property ($rose(irq) |-> lo < DEBOUNCE_CYCLES + 3) else $error("irq held");
	a_irq_after_sec: assert property ($rose(irq) |-> xr >= 32768) else $error("irq early");
	a_irq_clear_why: assert property ($fell(irq) |-> lo >= DEBOUNCE_CYCLES || qt < 16) else $error("irq drop");
	a_irq_latched: assert property (irq && qt > 16 && lo == 0 |=> irq) else $error("irq lost");
	c_ack: cover property ($rose(sda_oe));
	c_irq_up: cover property ($rose(irq));
	c_irq_down: cover property ($fell(irq));
endmodule

bind wct_timer wct_timer_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_wct_timer_checker (.*);
